// File: src/sar_adc_control_unit.v
// control logic of a 10-bit successive-approximation converter
// assumes a comparator and ladder front end on the far side, one clock and a plain register port
`timescale 1ns/100ps
`include "sar_adc_regs.vh"
module sar_adc_control_unit #(
  parameter CONV_CYCLES = `CONV_MACHINE_CYCLES,
  parameter MC_DIV      = `CLOCKS_PER_MACHINE_CYCLE
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       external_trigger_pin,
  input  wire       power_down,
  input  wire       cmp_out,
  output reg  [2:0] channel_select,
  output reg  [7:0] analog_pin_switch,
  output reg  [9:0] dac_code,
  output reg        sample_en,
  output wire       irq
);
  reg        converter_enable_r;
  reg        external_start_enable_r;
  reg        conversion_done_flag_r;
  reg        conversion_start_bit_r;
  reg [1:0]  converter_clock_divider_r;
  reg [9:0]  result_r;
  reg        irq_status_r;
  reg        irq_mask_r;
  reg        trig_s1_r;
  reg        trig_s2_r;
  reg        trig_seen_low_r;
  reg        trig_pend_r;
  reg [5:0]  mc_count_r;
  reg [3:0]  bit_idx_r;
  reg [9:0]  sar_r;
  reg        sar_busy_r;
  wire       mc_tick;
  wire       adc_tick;
  wire       wr_ctrl = reg_wr && (reg_addr == `ADDR_CONVERTER_CONTROL);
  wire       sw_start = wr_ctrl && reg_wdata[`BIT_START];
  // a control write may enable and start in one go, so the written enable counts at once
  wire       enable_now = wr_ctrl ? reg_wdata[`BIT_ENABLE] : converter_enable_r;
  // idle means not running and done flag clear
  wire       can_start = enable_now && !conversion_start_bit_r &&
                         !conversion_done_flag_r && !power_down;
  wire       hw_start = trig_pend_r && mc_tick && external_start_enable_r;
  wire       start_now = can_start && (sw_start || hw_start);
  wire       finish = conversion_start_bit_r && mc_tick &&
                      (mc_count_r == CONV_CYCLES - 1);
  wire [9:0] final_code = sar_r;

  sar_step_divider #(
    .MC_DIV (MC_DIV)
  ) u_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .div_sel  (converter_clock_divider_r),
    .mc_tick  (mc_tick),
    .adc_tick (adc_tick)
  );

  // trigger pin synchroniser, then level sampled only on machine-cycle boundaries
  always @(posedge clk) begin
    if (sys_rst) begin
      trig_s1_r       <= 1'b0;
      trig_s2_r       <= 1'b0;
      trig_seen_low_r <= 1'b0;
      trig_pend_r     <= 1'b0;
    end else begin
      trig_s1_r <= external_trigger_pin;
      trig_s2_r <= trig_s1_r;
      if (mc_tick) begin
        trig_seen_low_r <= !trig_s2_r;
        // a low machine cycle followed by a high one counts as the edge
        trig_pend_r     <= trig_seen_low_r && trig_s2_r && external_start_enable_r;
      end
    end
  end

  // conversion sequencing; a software start lands at once, a trigger start on a machine-cycle boundary
  always @(posedge clk) begin
    if (sys_rst) begin
      conversion_start_bit_r <= 1'b0;
      conversion_done_flag_r <= 1'b0;
      mc_count_r             <= 6'h00;
      result_r               <= 10'h000;
    end else begin
      if (power_down || !enable_now) begin
        conversion_start_bit_r <= 1'b0;
        mc_count_r             <= 6'h00;
      end else if (start_now) begin
        conversion_start_bit_r <= 1'b1;
        mc_count_r             <= 6'h00;
      end else if (finish) begin
        conversion_start_bit_r <= 1'b0;
        result_r               <= final_code;
      end else if (conversion_start_bit_r && mc_tick) begin
        mc_count_r <= mc_count_r + 6'h01;
      end
      // writing zero to start does not stop a conversion
      if (finish && !power_down && enable_now)
        conversion_done_flag_r <= 1'b1;
      else if (wr_ctrl && !reg_wdata[`BIT_DONE])
        conversion_done_flag_r <= 1'b0;
    end
  end

  // successive approximation on converter-clock ticks, msb first
  always @(posedge clk) begin
    if (sys_rst) begin
      sar_r      <= 10'h000;
      bit_idx_r  <= 4'h9;
      sar_busy_r <= 1'b0;
      dac_code   <= 10'h000;
      sample_en  <= 1'b0;
    end else if (!conversion_start_bit_r) begin
      sar_busy_r <= 1'b0;
      bit_idx_r  <= 4'h9;
      sample_en  <= 1'b0;
      if (start_now) begin
        sar_r      <= 10'h200;
        dac_code   <= 10'h200;
        sar_busy_r <= 1'b1;
        sample_en  <= 1'b1;
      end
    end else if (sample_en) begin
      // first compare waits one cycle so the front end holds its sample first
      sample_en <= 1'b0;
    end else if (adc_tick && sar_busy_r) begin
      // every divider setting finishes all ten bits before the machine-cycle count ends
      sar_r[bit_idx_r] <= cmp_out;
      if (bit_idx_r == 4'h0) begin
        sar_busy_r <= 1'b0;
        dac_code   <= {sar_r[9:1], cmp_out};
      end else begin
        sar_r[bit_idx_r - 4'h1] <= 1'b1;
        dac_code <= (sar_r & ~(10'h001 << bit_idx_r)) |
                    ({9'h000, cmp_out} << bit_idx_r) |
                    (10'h001 << (bit_idx_r - 4'h1));
        bit_idx_r <= bit_idx_r - 4'h1;
      end
    end
  end

  // software-owned configuration
  always @(posedge clk) begin
    if (sys_rst) begin
      converter_enable_r        <= 1'b0;
      external_start_enable_r   <= 1'b0;
      channel_select            <= 3'h0;
      converter_clock_divider_r <= `CLKDIV_RESET;
      analog_pin_switch         <= `PIN_SWITCH_RESET;
      irq_mask_r                <= `IRQ_MASK_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CONVERTER_CONTROL: begin
          converter_enable_r      <= reg_wdata[`BIT_ENABLE];
          external_start_enable_r <= reg_wdata[`BIT_EXT_START_EN];
          if (!conversion_start_bit_r)
            channel_select <= reg_wdata[`POS_CHANNEL +: 3];
        end
        `ADDR_RESULT_LOW_CLKSEL:
          converter_clock_divider_r <= reg_wdata[`POS_CLKDIV +: 2];
        `ADDR_ANALOG_PIN_SWITCH:
          analog_pin_switch <= reg_wdata;
        `ADDR_IRQ_MASK:
          irq_mask_r <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // sticky completion event, cleared by writing one; a new event wins
  always @(posedge clk) begin
    if (sys_rst)
      irq_status_r <= 1'b0;
    else if (finish && !power_down && enable_now)
      irq_status_r <= 1'b1;
    else if (reg_wr && reg_addr == `ADDR_IRQ_STATUS && reg_wdata[0])
      irq_status_r <= 1'b0;
  end

  assign irq = irq_status_r && irq_mask_r;

  // read port; unmapped addresses read zero
  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CONVERTER_CONTROL:
          reg_rdata <= {converter_enable_r, 1'b1, external_start_enable_r,
                        conversion_done_flag_r, conversion_start_bit_r, channel_select};
        `ADDR_RESULT_LOW_CLKSEL:
          reg_rdata <= {converter_clock_divider_r, 4'h0, result_r[1:0]};
        `ADDR_RESULT_HIGH:
          reg_rdata <= result_r[9:2];
        `ADDR_ANALOG_PIN_SWITCH:
          reg_rdata <= analog_pin_switch;
        `ADDR_IRQ_STATUS:
          reg_rdata <= {7'h00, irq_status_r};
        `ADDR_IRQ_MASK:
          reg_rdata <= {7'h00, irq_mask_r};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end
endmodule

// File: src/sar_adc_regs.vh
// register offsets, field positions, reset values and timing counts of the converter control
// assumes an 8-bit register port with byte addresses equal to the special register addresses
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH
`define ADDR_CONVERTER_CONTROL   8'hc0
`define ADDR_RESULT_LOW_CLKSEL   8'hc1
`define ADDR_RESULT_HIGH         8'hc2
`define ADDR_ANALOG_PIN_SWITCH   8'hc6
`define ADDR_IRQ_STATUS          8'hc8
`define ADDR_IRQ_MASK            8'hc9
`define BIT_ENABLE               7
`define BIT_FIXED_ONE            6
`define BIT_EXT_START_EN         5
`define BIT_DONE                 4
`define BIT_START                3
`define POS_CHANNEL              0
`define POS_CLKDIV               6
`define CONTROL_RESET            8'h00
`define CLKDIV_RESET             2'h0
`define PIN_SWITCH_RESET         8'h00
`define IRQ_MASK_RESET           1'b0
`define CONV_MACHINE_CYCLES      50
`define CLOCKS_PER_MACHINE_CYCLE 4
`endif

// File: src/sar_step_divider.v
// divider making one-cycle enable pulses for machine cycles and converter clock
// assumes a single clk domain and a synchronous active-high reset
`timescale 1ns/100ps
module sar_step_divider #(
  parameter MC_DIV = 4
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [1:0] div_sel,
  output reg        mc_tick,
  output reg        adc_tick
);
  reg [7:0] cnt_r;
  wire [7:0] adc_mask = (div_sel == 2'h1) ? 8'h07 :
                        (div_sel == 2'h2) ? 8'h0f : 8'h03;
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r    <= 8'h00;
      mc_tick  <= 1'b0;
      adc_tick <= 1'b0;
    end else begin
      cnt_r    <= cnt_r + 8'h01;
      mc_tick  <= ((cnt_r % MC_DIV) == (MC_DIV - 1)); // reserved code 11 falls back to /4
      adc_tick <= ((cnt_r & adc_mask) == adc_mask);
    end
  end
endmodule

// File: testbench/adc_front_model.sv
// comparator and ladder front end with a sample and hold per conversion
// assumes the bench sets one 10-bit level per channel
`timescale 1ns/100ps
module adc_front_model (
  input  wire        clk,
  input  wire [79:0] levels,
  input  wire [2:0]  channel_select,
  input  wire        sample_en,
  input  wire [9:0]  dac_code,
  output wire        cmp_out
);
  logic [9:0] held = 10'h000;
  always @(posedge clk)
    if (sample_en) held <= levels[channel_select*10 +: 10];
  // half-code offset so the settled code equals the level, no rounding doubt
  assign cmp_out = {held, 1'b1} > {dac_code, 1'b0};
endmodule

// File: testbench/sar_adc_monitor.sv
// port checker for the converter control unit
// assumes one clk domain with sys_rst synchronous active high
`timescale 1ns/100ps
module sar_adc_monitor #(
  parameter CONV_CYCLES = 50,
  parameter MC_DIV      = 4
) (
  input wire       clk,
  input wire       sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       power_down,
  input wire [2:0] channel_select,
  input wire [7:0] analog_pin_switch,
  input wire       sample_en,
  input wire       irq
);
  localparam int SPAN = CONV_CYCLES * MC_DIV;
  // a software start may land late in a machine cycle, so a run can be one machine cycle short
  localparam int MIN_GAP = SPAN - MC_DIV;
  logic [11:0] since_r;
  // saturates so a long idle never wraps into a false early start
  // an abort frees the converter at once, so the count saturates and the next start needs no spacing
  always @(posedge clk)
    if (sys_rst) since_r <= 12'hfff;
    else if (sample_en) since_r <= 12'h000;
    else if (power_down || (reg_wr && reg_addr == 8'hc0 && !reg_wdata[7])) since_r <= 12'hfff;
    else if (since_r != 12'hfff) since_r <= since_r + 12'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_sample_pulse: assert property (sample_en |=> !sample_en)
    else $error("sample pulse too long");
  a_start_spacing: assert property (sample_en |-> since_r >= MIN_GAP)
    else $error("start inside running conversion");
  a_pd_no_start: assert property (power_down && $past(power_down) |-> !sample_en)
    else $error("start during power down");
  a_chan_hold: assert property (sample_en |=> $stable(channel_select) [*8])
    else $error("channel moved during conversion");
  a_done_time: assert property ($rose(irq) |-> since_r >= SPAN - 8 && since_r <= SPAN + 8)
    else $error("completion at wrong time");
  a_irq_clear: assert property (reg_wr && reg_addr == 8'hc8 && reg_wdata[0] |=> !irq)
    else $error("interrupt not cleared");
  a_pin_switch: assert property (reg_wr && reg_addr == 8'hc6 |=>
    analog_pin_switch == $past(reg_wdata))
    else $error("pin switch not written");
  c_start: cover property (sample_en);
  c_done: cover property ($rose(irq));
  c_abort: cover property (power_down && since_r < SPAN);
endmodule
bind sar_adc_control_unit sar_adc_monitor #(.CONV_CYCLES(CONV_CYCLES), .MC_DIV(MC_DIV)) mon (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down(power_down),
  .channel_select(channel_select), .analog_pin_switch(analog_pin_switch),
  .sample_en(sample_en), .irq(irq));

// File: testbench/tb.sv
// self-checking bench: register port tasks, front end model, queued read checks
// assumes the control unit at default counts and a 125 MHz clock
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic        external_trigger_pin = 1'b0, power_down = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, ps;
  logic [79:0] levels = 80'h0;
  logic [9:0]  lvl;
  logic [1:0]  dv;
  wire  [7:0]  reg_rdata, analog_pin_switch;
  wire  [2:0]  channel_select;
  wire  [9:0]  dac_code;
  wire         sample_en, irq, cmp_out;
  logic [7:0]  exp_q[$];
  int          err_count = 0, compares = 0, cycles = 0;
  initial forever #4 clk = ~clk;
  sar_adc_control_unit dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_trigger_pin(external_trigger_pin), .power_down(power_down), .cmp_out(cmp_out),
    .channel_select(channel_select), .analog_pin_switch(analog_pin_switch),
    .dac_code(dac_code), .sample_en(sample_en), .irq(irq));
  adc_front_model front (.clk(clk), .levels(levels), .channel_select(channel_select),
    .sample_en(sample_en), .dac_code(dac_code), .cmp_out(cmp_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // idle cycle after each strobe keeps one assignment per signal per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq;
    for (int n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clk);
    if (irq !== 1'b1) err_count++;
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hf8ad));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(8'hc0, 8'h40);
    rd(8'hc1, 8'h00);
    rd(8'hc2, 8'h00);
    rd(8'hc3, 8'h00);
    wr(8'hc0, 8'h08);
    rd(8'hc0, 8'h40);
    ps = 8'($urandom);
    wr(8'hc6, ps);
    rd(8'hc6, ps);
    wr(8'hc9, 8'h01);
    for (int i = 0; i < 8; i++) begin
      lvl = 10'($urandom);
      dv = 2'(i % 2);
      levels[i*10 +: 10] <= lvl;
      wr(8'hc1, {dv, 6'h00});
      wr(8'hc0, 8'h88 | i[7:0]);
      if (i == 3) begin
        repeat (40) @(posedge clk);
        wr(8'hc0, 8'h8d);
        wr(8'hc0, 8'h80);
      end
      wait_irq();
      rd(8'hc2, lvl[9:2]);
      rd(8'hc1, {dv, 4'h0, lvl[1:0]});
      wr(8'hc0, 8'h98 | i[7:0]);
      rd(8'hc0, 8'hd0 | i[7:0]);
      wr(8'hc0, 8'h80 | i[7:0]);
      wr(8'hc8, 8'h01);
      check({7'h00, irq}, 8'h00);
    end
    lvl = 10'($urandom);
    levels[9:0] <= lvl;
    wr(8'hc0, 8'ha0);
    repeat (8) @(posedge clk);
    external_trigger_pin <= 1'b1;
    repeat (8) @(posedge clk);
    external_trigger_pin <= 1'b0;
    wait_irq();
    rd(8'hc2, lvl[9:2]);
    rd(8'hc0, 8'hf0);
    wr(8'hc0, 8'h80);
    wr(8'hc8, 8'h01);
    repeat (8) @(posedge clk);
    external_trigger_pin <= 1'b1;
    repeat (300) @(posedge clk);
    external_trigger_pin <= 1'b0;
    check({7'h00, irq}, 8'h00);
    levels[9:0] <= ~lvl;
    wr(8'hc0, 8'h88);
    repeat (40) @(posedge clk);
    power_down <= 1'b1;
    repeat (4) @(posedge clk);
    power_down <= 1'b0;
    repeat (300) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    rd(8'hc0, 8'hc0);
    rd(8'hc2, lvl[9:2]);
    @(posedge clk);
    finish_test();
  end
endmodule
